// [hdl/ifs_irq_status.sv]
// Interrupt flags and FIFO status registers behind an Avalon-MM slave
//
// The implementer's own choice: the Avalon-MM slave port.
`timescale 1ns/1ns
`default_nettype none

module ifs_irq_status (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic irq,
  input wire logic [7:1] mainEvt,
  input wire ifs_pkg::ifs_rx_evt_t rxEvt,
  input wire ifs_pkg::ifs_nvm_evt_t nvmEvt,
  input wire ifs_pkg::ifs_fifo_evt_t fifoEvt,
  input wire logic cmdSetDefault,
  input wire logic cmdFifoClear
);
  import ifs_pkg::*;

  // Register select decode, reused for every register
  function automatic logic regHit(input logic [7:0] addr, input logic [5:0] idx);
    regHit = (addr == {idx, 2'b00});
  endfunction : regHit

  logic ack;
  logic [7:0] auxMask;
  logic [7:0] auxFlags;
  logic [7:0] mainFlags;
  logic [5:0] unreadCount;
  logic fifoUnf;
  logic fifoOvr;
  logic lastIncomplete;
  logic [2:0] lastBits;
  logic missingParity;

  // Bus handshake: one wait cycle, then the answer; frozen with ce
  wire busReq = read | write;
  wire accept = busReq & ack & ce;
  wire rdAccept = read & accept;
  wire wrAccept = write & accept;
  assign waitrequest = busReq & ~(ack & ce);

  // Register selects
  wire hitMain = regHit(address, IDX_MAIN);
  wire hitAuxMask = regHit(address, IDX_AUX_MASK);
  wire hitAux = regHit(address, IDX_AUX);
  wire hitSt1 = regHit(address, IDX_FIFO_ST1);
  wire hitSt2 = regHit(address, IDX_FIFO_ST2);

  // Side effects of completed accesses
  wire mainRead = rdAccept & hitMain;
  wire auxRead = rdAccept & hitAux;
  wire auxW1c = wrAccept & hitAux & byteenable[0];
  wire maskWrite = wrAccept & hitAuxMask & byteenable[0];
  wire fifoInit = cmdSetDefault | cmdFifoClear;

  // FIFO occupancy; a simultaneous pop frees room for the push
  wire popOk = fifoEvt.pop & (unreadCount != COUNT_RST);
  wire pushOk = fifoEvt.push & ((unreadCount != FIFO_DEPTH) | popOk);
  wire unfEvt = fifoEvt.pop & (unreadCount == COUNT_RST);
  wire ovrEvt = fifoEvt.push & ~pushOk;
  wire [5:0] next_unreadCount = unreadCount + {5'h00, pushOk} - {5'h00, popOk};

  // Auxiliary event sources
  wire missingParityEvt = rxEvt.frameEnd & rxEvt.parityMissing;
  logic [7:0] auxSet;
  assign auxSet[AUX_DESELECT] = rxEvt.deselect;
  assign auxSet[AUX_FRAMING] = rxEvt.framingErr | missingParityEvt;
  assign auxSet[AUX_PARITY] = rxEvt.parityErr;
  assign auxSet[AUX_CRC] = rxEvt.crcErr;
  assign auxSet[AUX_BUFFER] = unfEvt | ovrEvt;
  assign auxSet[AUX_NVM_DONE] = nvmEvt.fromHost & nvmEvt.writeDone;
  assign auxSet[AUX_NVM_ERR] = nvmEvt.fromHost
    & (nvmEvt.writeProtected | nvmEvt.writeNoAddr);
  assign auxSet[AUX_NVM_ABORT] = nvmEvt.hostAccessAborted;

  // Clear on read plus write-one-to-clear
  wire [7:0] auxClr = {8{auxRead}} | ({8{auxW1c}} & writedata[7:0]);

  // Summary bit follows unmasked auxiliary events
  wire auxSummarySet = |(auxSet & ~auxMask);
  wire [7:0] mainSet = {mainEvt, auxSummarySet};
  wire [7:0] mainClr = {{7{mainRead}}, auxRead};

  // Auxiliary flags, cleared by read and by restore-defaults
  ifs_sticky_bits #(
    .W(8)
  ) u_aux (
    .sys_clk(sys_clk),
    .rst(rst),
    .ce(ce),
    .init(cmdSetDefault),
    .set(auxSet),
    .clr(auxClr),
    .flags(auxFlags)
  );

  // Main flags; bit 0 waits for the auxiliary read
  ifs_sticky_bits #(
    .W(8)
  ) u_main (
    .sys_clk(sys_clk),
    .rst(rst),
    .ce(ce),
    .init(cmdSetDefault),
    .set(mainSet),
    .clr(mainClr),
    .flags(mainFlags)
  );

  // Level output; combinational so it drops with the clearing edge
  assign irq = |mainFlags;

  // Bus acknowledge flop
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      ack <= 1'b0;
    else if (ce)
      ack <= busReq & ~ack;
  end

  // Auxiliary mask, software owned
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      auxMask <= AUX_MASK_RST;
    else if (ce)
    begin
      if (cmdSetDefault)
        auxMask <= AUX_MASK_RST;
      else if (maskWrite)
        auxMask <= writedata[7:0];
    end
  end

  // Unread byte count
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      unreadCount <= COUNT_RST;
    else if (ce)
      unreadCount <= fifoInit ? COUNT_RST : next_unreadCount;
  end

  // Underflow and overflow causes, held until the FIFO is cleared
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      fifoUnf <= 1'b0;
      fifoOvr <= 1'b0;
    end
    else if (ce)
    begin
      fifoUnf <= ~fifoInit & (fifoUnf | unfEvt);
      fifoOvr <= ~fifoInit & (fifoOvr | ovrEvt);
    end
  end

  // Last byte details captured at frame end
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      lastIncomplete <= 1'b0;
      lastBits <= LAST_BITS_RST;
      missingParity <= 1'b0;
    end
    else if (ce)
    begin
      if (fifoInit)
      begin
        lastIncomplete <= 1'b0;
        lastBits <= LAST_BITS_RST;
        missingParity <= 1'b0;
      end
      else if (rxEvt.frameEnd)
      begin
        lastIncomplete <= rxEvt.lastIncomplete;
        lastBits <= rxEvt.lastIncomplete ? rxEvt.lastBits : LAST_BITS_RST;
        missingParity <= rxEvt.parityMissing;
      end
    end
  end

  // Read selection; unmapped addresses read as zero
  wire [7:0] st1Value = {2'b00, unreadCount};
  logic [7:0] st2Value;
  assign st2Value[7] = 1'b0;
  assign st2Value[ST2_UNDERFLOW] = fifoUnf;
  assign st2Value[ST2_OVERFLOW] = fifoOvr;
  assign st2Value[ST2_INCOMPLETE] = lastIncomplete;
  assign st2Value[ST2_INCOMPLETE-1:ST2_LAST_BITS_LSB] = lastBits;
  assign st2Value[ST2_MISSING_PARITY] = missingParity;
  wire [7:0] rdMux = ({8{hitMain}} & mainFlags)
    | ({8{hitAuxMask}} & auxMask)
    | ({8{hitAux}} & auxFlags)
    | ({8{hitSt1}} & st1Value)
    | ({8{hitSt2}} & st2Value);

  // Read data captured in the wait cycle, stands at the answer edge
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      readdata <= 32'h00000000;
    else if (ce & read & ~ack)
      readdata <= {24'h000000, rdMux};
  end

  // Checks on the flag, count and bus handshake behaviour
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  a_main_read_clear: assert property (
    mainRead & ~(|mainEvt) & ~cmdSetDefault |=> mainFlags[7:1] == 7'h00)
    else $error("main flags not cleared by read");

  a_summary_hold_bit: assert property (
    mainFlags[MAIN_AUX_SUMMARY] & ~(ce & (auxRead | cmdSetDefault))
      |=> mainFlags[MAIN_AUX_SUMMARY])
    else $error("summary bit cleared without auxiliary read");

  a_summary_set_bit: assert property (
    ce & auxSummarySet & ~cmdSetDefault |=> mainFlags[MAIN_AUX_SUMMARY] & irq)
    else $error("summary bit not set by auxiliary event");

  a_aux_read_clear: assert property (
    auxRead & ~(|auxSet) & ~cmdSetDefault |=> auxFlags == 8'h00)
    else $error("auxiliary flags not cleared by read");

  a_default_clears_all: assert property (
    ce & cmdSetDefault |=> (mainFlags == MAIN_RST) && (auxFlags == AUX_RST)
      && (unreadCount == COUNT_RST) && (auxMask == AUX_MASK_RST))
    else $error("restore defaults left state set");

  a_nvm_side_only: assert property (
    ce & ~nvmEvt.fromHost & ~auxFlags[AUX_NVM_DONE] |=> ~auxFlags[AUX_NVM_DONE])
    else $error("write done flagged for a contactless write");

  a_count_in_range: assert property (
    unreadCount <= FIFO_DEPTH)
    else $error("unread count above depth");

  a_underflow_flags: assert property (
    ce & fifoEvt.pop & (unreadCount == COUNT_RST) & ~fifoInit
      |=> fifoUnf & auxFlags[AUX_BUFFER] & (unreadCount == $past(unreadCount) + 6'h01)
        || fifoUnf & auxFlags[AUX_BUFFER] & (unreadCount == COUNT_RST))
    else $error("underflow not reported");

  a_error_still_pushes: assert property (
    ce & fifoEvt.push & ~fifoEvt.pop & rxEvt.crcErr & ~fifoInit
      & (unreadCount < FIFO_DEPTH) |=> (unreadCount == $past(unreadCount) + 6'h01)
        & auxFlags[AUX_CRC])
    else $error("erroneous frame byte dropped");

  a_bus_one_wait: assert property (
    ce & busReq & ~ack ##1 ce & busReq |-> ~waitrequest)
    else $error("answer not given after one wait cycle");

  a_frozen_bus_wait: assert property (
    busReq & ~ce |-> waitrequest)
    else $error("bus answered while clock enable low");

  // Low enable must leave every flag and the count untouched
  a_frozen_state_hold: assert property (
    ~ce |=> $stable(auxFlags) && $stable(mainFlags) && $stable(unreadCount))
    else $error("state moved while clock enable low");

  a_overflow_flags: assert property (
    ce & fifoEvt.push & ~fifoEvt.pop & (unreadCount == FIFO_DEPTH) & ~fifoInit
      |=> fifoOvr & auxFlags[AUX_BUFFER] & (unreadCount == FIFO_DEPTH))
    else $error("overflow not reported");

  a_fifo_clear_init: assert property (
    ce & cmdFifoClear |=> (unreadCount == COUNT_RST) & ~fifoUnf & ~fifoOvr & ~lastIncomplete)
    else $error("FIFO clear left state set");

  // Push and pop move the count by one at most per cycle
  a_count_one_step: assert property (
    ce & ~fifoInit |=> (unreadCount == $past(unreadCount))
      || (unreadCount == $past(unreadCount) + 6'h01)
      || (unreadCount == $past(unreadCount) - 6'h01))
    else $error("unread count moved by more than one");

  a_st1_reserved_zero: assert property (
    ce & read & ~ack & hitSt1 |=> readdata[7:6] == 2'b00)
    else $error("reserved count bits not zero");

  a_last_byte_capture: assert property (
    ce & rxEvt.frameEnd & ~fifoInit |=> (lastIncomplete == $past(rxEvt.lastIncomplete))
      && (lastBits == ($past(rxEvt.lastIncomplete) ? $past(rxEvt.lastBits) : LAST_BITS_RST)))
    else $error("last byte details not captured");

  a_missing_parity_frame: assert property (
    ce & rxEvt.frameEnd & rxEvt.parityMissing & ~fifoInit
      |=> missingParity & auxFlags[AUX_FRAMING])
    else $error("missing parity not flagged as framing error");

  a_rx_error_flags: assert property (
    ce & (rxEvt.parityErr | rxEvt.crcErr) & ~cmdSetDefault
      |=> (auxFlags[AUX_PARITY] | ~$past(rxEvt.parityErr)) & (auxFlags[AUX_CRC] | ~$past(rxEvt.crcErr)))
    else $error("receive error not flagged");

  a_write_error_flag: assert property (
    ce & nvmEvt.fromHost & (nvmEvt.writeProtected | nvmEvt.writeNoAddr) & ~cmdSetDefault
      |=> auxFlags[AUX_NVM_ERR])
    else $error("host write error not flagged");

  a_abort_flag_set: assert property (
    ce & nvmEvt.hostAccessAborted & ~cmdSetDefault |=> auxFlags[AUX_NVM_ABORT])
    else $error("aborted host access not flagged");

  // A fully masked event must not reach the summary bit
  a_mask_blocks_summary: assert property (
    ce & ~mainFlags[MAIN_AUX_SUMMARY] & (|auxSet) & ((auxSet & ~auxMask) == 8'h00)
      |=> ~mainFlags[MAIN_AUX_SUMMARY])
    else $error("masked event raised the summary bit");

  a_irq_released: assert property (
    ce & auxRead & (mainFlags[7:1] == 7'h00) & (mainSet == 8'h00) |=> ~irq)
    else $error("interrupt held after all flags cleared");

endmodule : ifs_irq_status
`default_nettype wire

// [hdl/ifs_pkg.sv]
// Package: offsets, field positions, reset values and carriers for the status block
package ifs_pkg;

  // Register indices; the byte address is four times the index
  localparam logic [5:0] IDX_MAIN = 6'h00;
  localparam logic [5:0] IDX_AUX_MASK = 6'h09;
  localparam logic [5:0] IDX_AUX = 6'h0B;
  localparam logic [5:0] IDX_FIFO_ST1 = 6'h0C;
  localparam logic [5:0] IDX_FIFO_ST2 = 6'h0D;

  // Reset values
  localparam logic [7:0] MAIN_RST = 8'h00;
  localparam logic [7:0] AUX_RST = 8'h00;
  localparam logic [7:0] AUX_MASK_RST = 8'h00;
  localparam logic [5:0] COUNT_RST = 6'h00;
  localparam logic [2:0] LAST_BITS_RST = 3'h0;

  // Auxiliary flag positions
  localparam int AUX_DESELECT = 7;
  localparam int AUX_FRAMING = 6;
  localparam int AUX_PARITY = 5;
  localparam int AUX_CRC = 4;
  localparam int AUX_BUFFER = 3;
  localparam int AUX_NVM_DONE = 2;
  localparam int AUX_NVM_ERR = 1;
  localparam int AUX_NVM_ABORT = 0;

  // Main register summary bit
  localparam int MAIN_AUX_SUMMARY = 0;

  // Second FIFO status register field positions
  localparam int ST2_UNDERFLOW = 6;
  localparam int ST2_OVERFLOW = 5;
  localparam int ST2_INCOMPLETE = 4;
  localparam int ST2_LAST_BITS_LSB = 1;
  localparam int ST2_MISSING_PARITY = 0;

  // FIFO depth in bytes
  localparam logic [5:0] FIFO_DEPTH = 6'h20;

  // Receive path events, one-cycle strobes
  typedef struct packed {
    logic deselect;
    logic framingErr;
    logic parityErr;
    logic crcErr;
    logic frameEnd;
    logic lastIncomplete;
    logic [2:0] lastBits;
    logic parityMissing;
  } ifs_rx_evt_t;

  // Non-volatile memory events, one-cycle strobes
  typedef struct packed {
    logic fromHost;
    logic writeDone;
    logic writeProtected;
    logic writeNoAddr;
    logic hostAccessAborted;
  } ifs_nvm_evt_t;

  // FIFO traffic strobes
  typedef struct packed {
    logic push;
    logic pop;
  } ifs_fifo_evt_t;

endpackage : ifs_pkg

// [hdl/ifs_sticky_bits.sv]
// Bank of sticky flags: set wins over clear, init wins over both
`timescale 1ns/1ns
`default_nettype none
module ifs_sticky_bits #(
  parameter int W = 8
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic init,
  input wire logic [W-1:0] set,
  input wire logic [W-1:0] clr,
  output logic [W-1:0] flags
);

  // One flop per flag; an event in the clearing cycle survives
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      always_ff @(posedge sys_clk or posedge rst)
      begin
        if (rst)
          flags[i] <= 1'b0;
        else if (ce)
          flags[i] <= init ? 1'b0 : (set[i] | (flags[i] & ~clr[i]));
      end
    end
  endgenerate

endmodule : ifs_sticky_bits
`default_nettype wire

// [verif/ifs_host_model.sv]
// Host microcontroller model: Avalon-MM master for the status registers
`timescale 1ns/1ns
`default_nettype none
module ifs_host_model (
  input wire logic sys_clk,
  input wire logic waitrequest,
  output logic [7:0] address,
  output logic read,
  output logic write,
  output logic [31:0] writedata,
  output logic [3:0] byteenable
);
  // Idle bus values at time zero
  initial
  begin
    address = 8'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h00000000;
    byteenable = 4'h1;
  end

  // One access; held until waitrequest is sampled low at a rising edge
  task access(input logic isWrite, input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    address <= a;
    read <= ~isWrite;
    write <= isWrite;
    writedata <= {24'h000000, d};
    // No limit of its own: a dead slave is caught by the bench watchdog
    @(posedge sys_clk);
    while (waitrequest)
      @(posedge sys_clk);
    read <= 1'b0;
    write <= 1'b0;
    // Released lines show a changed value, never the stale one
    address <= ~a;
    writedata <= ~writedata;
  endtask : access
endmodule : ifs_host_model
`default_nettype wire

// [verif/tb.sv]
// Self-checking bench for the interrupt and FIFO status block
`timescale 1ns/1ns
`default_nettype none
module tb;
  import ifs_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] address;
  logic read, write, waitrequest, irq;
  logic [31:0] writedata, readdata;
  logic [3:0] byteenable;
  logic [7:1] mainEvt = '0;
  ifs_rx_evt_t rxEvt = '0;
  ifs_nvm_evt_t nvmEvt = '0;
  ifs_fifo_evt_t fifoEvt = '0;
  logic cmdSetDefault = 1'b0;
  logic cmdFifoClear = 1'b0;
  logic ce = 1'b1;
  int err_total = 0;
  int tests_run = 0;
  logic [7:0] expQ[$];
  logic [4:0] nvmTab [9] = '{5'h01, 5'h12, 5'h18, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h14};
  logic [7:0] addrTab [6] = '{8'h00, 8'h24, 8'h2C, 8'h30, 8'h34, 8'h3C};

  always #5 sys_clk = ~sys_clk;

  ifs_irq_status i_dut (.sys_clk(sys_clk), .rst(rst), .ce(ce), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .irq(irq), .mainEvt(mainEvt),
    .rxEvt(rxEvt), .nvmEvt(nvmEvt), .fifoEvt(fifoEvt), .cmdSetDefault(cmdSetDefault),
    .cmdFifoClear(cmdFifoClear));

  ifs_host_model i_host (.sys_clk(sys_clk), .waitrequest(waitrequest), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(byteenable));

  task chk(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e)
    begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  // Note the expected value, then let the host read
  task rd(input logic [7:0] a, input logic [7:0] e);
    expQ.push_back(e);
    i_host.access(1'b0, a, 8'h00);
  endtask : rd

  task wr(input logic [7:0] a, input logic [7:0] d);
    i_host.access(1'b1, a, d);
  endtask : wr

  // One-cycle event strobes
  task ev(input logic [7:1] m, input ifs_rx_evt_t r, input ifs_nvm_evt_t n,
    input ifs_fifo_evt_t f);
    @(posedge sys_clk);
    mainEvt <= m;
    rxEvt <= r;
    nvmEvt <= n;
    fifoEvt <= f;
    @(posedge sys_clk);
    mainEvt <= '0;
    rxEvt <= '0;
    nvmEvt <= '0;
    fifoEvt <= '0;
  endtask : ev

  task cmd(input logic sd, input logic fc);
    @(posedge sys_clk);
    cmdSetDefault <= sd;
    cmdFifoClear <= fc;
    @(posedge sys_clk);
    cmdSetDefault <= 1'b0;
    cmdFifoClear <= 1'b0;
  endtask : cmd

  task irqIs(input logic e);
    @(negedge sys_clk);
    chk({7'h00, irq}, {7'h00, e});
  endtask : irqIs

  // Read data stand at the accept edge, so take them there
  always @(posedge sys_clk)
  begin
    if (read && !waitrequest)
      chk(readdata[7:0], expQ.pop_front());
  end

  task report_and_stop;
    $display("Checks: %0d, mismatches: %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop

  // Whole run needs a few hundred cycles
  initial
  begin
    #200000;
    err_total++;
    report_and_stop();
  end

  initial
  begin
    logic [2:0] b;
    logic [7:1] m;
    int n, k;
    void'($urandom(57));
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    // Reset values, read-only and unmapped places
    wr(8'h00, 8'hFF);
    foreach (addrTab[j]) rd(addrTab[j], 8'h00);
    irqIs(1'b0);
    // Every auxiliary source, then clear by reading
    for (int i = 0; i < 9; i++)
    begin
      b = (i == 8) ? 3'd1 : i[2:0];
      ev(7'h00, (i > 3 && i < 8) ? 10'h004 << i : '0, nvmTab[i], (i == 3) ? 2'b01 : 2'b00);
      irqIs(1'b1);
      rd(8'h00, 8'h01);
      rd(8'h00, 8'h01);
      rd(8'h2C, 8'h01 << b);
      rd(8'h00, 8'h00);
      irqIs(1'b0);
    end
    rd(8'h34, 8'h40);
    ev(7'h00, '0, 5'h08, 2'b00);
    rd(8'h2C, 8'h00);
    // Other main events beside the summary bit
    repeat (3)
    begin
      m = 7'($urandom_range(1, 127));
      ev(m, 10'h200, '0, 2'b00);
      rd(8'h00, {m, 1'b1});
      rd(8'h00, 8'h01);
      rd(8'h2C, 8'h80);
    end
    // Byte count, overflow and clear
    cmd(1'b0, 1'b1);
    rd(8'h34, 8'h00);
    n = $urandom_range(1, 31);
    k = $urandom_range(0, n);
    repeat (n) ev(7'h00, '0, '0, 2'b10);
    repeat (k) ev(7'h00, '0, '0, 2'b01);
    rd(8'h30, 8'(n - k));
    repeat (32 - n + k) ev(7'h00, '0, '0, 2'b10);
    rd(8'h30, 8'h20);
    ev(7'h00, '0, '0, 2'b10);
    rd(8'h30, 8'h20);
    rd(8'h34, 8'h20);
    rd(8'h2C, 8'h08);
    cmd(1'b0, 1'b1);
    rd(8'h30, 8'h00);
    // Erroneous short frame still stores its byte
    b = 3'($urandom_range(1, 7));
    ev(7'h00, {4'b0011, 2'b11, b, 1'b1}, '0, 2'b10);
    rd(8'h34, {3'b000, 1'b1, b, 1'b1});
    rd(8'h30, 8'h01);
    rd(8'h2C, 8'h70);
    ev(7'h00, 10'h020, '0, 2'b00);
    rd(8'h34, 8'h00);
    // Masked source sets its flag but no interrupt
    wr(8'h24, 8'h80);
    rd(8'h24, 8'h80);
    ev(7'h00, 10'h200, '0, 2'b00);
    irqIs(1'b0);
    rd(8'h00, 8'h00);
    rd(8'h2C, 8'h80);
    wr(8'h24, 8'h00);
    // Write-one-to-clear drops only the written bits
    ev(7'h00, 10'h240, '0, 2'b00);
    wr(8'h2C, 8'h80);
    rd(8'h00, 8'h01);
    rd(8'h2C, 8'h10);
    // Restore-defaults command clears everything
    ev(7'h7F, 10'h200, '0, 2'b10);
    cmd(1'b1, 1'b0);
    rd(8'h00, 8'h00);
    rd(8'h2C, 8'h00);
    rd(8'h30, 8'h00);
    irqIs(1'b0);
    // Clock enable low ignores strobes and stretches the bus wait
    @(posedge sys_clk);
    ce <= 1'b0;
    ev(7'h7F, 10'h200, '0, 2'b10);
    fork
      rd(8'h00, 8'h00);
      begin
        repeat (4) @(posedge sys_clk);
        ce <= 1'b1;
      end
    join
    rd(8'h2C, 8'h00);
    rd(8'h30, 8'h00);
    irqIs(1'b0);
    chk(8'(expQ.size()), 8'h00);
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
